// [flash_program_status_id_logic.sv]
`timescale 1ns/100ps
// Function
// - program takes two writes; address and data come from the second
// - after data accepted the program pulse is generated and timed inside
// - programming only clears bits; host targets erased bytes
// - after a program the interface stays in status-read mode
// - program succeeds only if lock bit clear and protect pin inactive
// - after read-status command every read returns status
// - read-status command accepted at any time, even while busy
// - error flags set only by command decode and the erase engine, cleared only by clear
// - bit seven low while busy, high when ready
// - bit five reports a failed erase
// - bit four reports a failed program
// - bits five and four together mark a command sequence error
// - bit one set when the targeted sector is protected or locked
// - protection sampled only at an erase or program attempt
// - in id mode address zero gives maker code, one device code
// - any valid command but product id leaves id mode; read-array only when not busy
// - codes 40h and 10h both start a byte program
// - read-array command ignored while an operation runs
module flash_program_status_id_logic (
    // clock and reset
    input  wire logic                              clk_sys_in,
    input  wire logic                              resetn_in,
    // decoded command write cycle
    input  wire logic                              cmd_wr_in,
    input  wire logic [flash_prog_pkg::ADDR_W-1:0] cmd_addr_in,
    input  wire logic [flash_prog_pkg::DATA_W-1:0] cmd_data_in,
    // decoded read cycle
    input  wire logic                              rd_in,
    input  wire logic [flash_prog_pkg::ADDR_W-1:0] rd_addr_in,
    output logic                                   rd_valid_out,
    output logic [flash_prog_pkg::DATA_W-1:0]      rd_data_out,
    // array read data for the current read address, same cycle
    input  wire logic [flash_prog_pkg::DATA_W-1:0] array_rd_data_in,
    // array program port
    output logic                                   prog_pulse_out,
    output logic [flash_prog_pkg::ADDR_W-1:0]      prog_addr_out,
    output logic [flash_prog_pkg::DATA_W-1:0]      prog_data_out,
    // sector lock of the addressed sector, from the lock registers
    input  wire logic                              sector_lock_in,
    // hardware protect pins, active low, asynchronous
    input  wire logic                              top_boot_lock_pin_n_in,
    input  wire logic                              write_protect_n_in,
    // erase engine handshake
    input  wire logic                              erase_busy_in,
    input  wire logic                              erase_done_in,
    input  wire logic                              erase_fail_in,
    input  wire logic                              erase_locked_in,
    // busy indication
    output logic                                   busy_out,
    output logic                                   ready_busy_out,
    output logic                                   ready_busy_oe_n_out,
    output logic [7:0]                             status_out
);

    // ============================================================
    // types
    typedef enum logic [3:0] {
        MODE_ARRAY  = 4'b0001,
        MODE_STATUS = 4'b0010,
        MODE_ID     = 4'b0100,
        MODE_PROG2  = 4'b1000
    } cmd_mode_t;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_PROG = 2'b10
    } eng_state_t;

    // ============================================================
    // declarations
    cmd_mode_t  mode_q;
    cmd_mode_t  mode_d;
    eng_state_t eng_q;
    logic [flash_prog_pkg::SYNC_STAGES-1:0] top_sync_q;
    logic [flash_prog_pkg::SYNC_STAGES-1:0] wp_sync_q;
    logic       top_active;
    logic       wp_active;
    logic       top_sector;
    logic       target_locked;
    logic       is_prog_cmd;
    logic       is_valid_cmd;
    logic       prog_accept;
    logic       prog_start;
    logic       prog_reject;
    logic       seq_error;
    logic       clear_status;
    logic       timer_pulse;
    logic       timer_done;
    logic       busy;
    logic       erase_err_q;
    logic       prog_err_q;
    logic       protect_err_q;
    logic [7:0] status;
    logic [7:0] id_byte;

    // ============================================================
    // protect pin synchronisers; only the last stage is read
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            top_sync_q <= '1;
            wp_sync_q  <= '1;
        end else begin
            top_sync_q <= {top_sync_q[0], top_boot_lock_pin_n_in};
            wp_sync_q  <= {wp_sync_q[0], write_protect_n_in};
        end
    end

    assign top_active = !top_sync_q[flash_prog_pkg::SYNC_STAGES-1];
    assign wp_active  = !wp_sync_q[flash_prog_pkg::SYNC_STAGES-1];

    // ============================================================
    // command decode
    // top boot sector is guarded by its own pin, all others by wp
    assign top_sector = cmd_addr_in[flash_prog_pkg::ADDR_W-1 -:4]
                        == flash_prog_pkg::TOP_SEC_TAG;
    // sampled only at the program attempt, never tracked
    assign target_locked = sector_lock_in
                         | (top_sector ? top_active : wp_active);

    assign is_prog_cmd = cmd_data_in == flash_prog_pkg::CMD_PROGRAM_A
                      || cmd_data_in == flash_prog_pkg::CMD_PROGRAM_B;

    // any address is accepted for these codes
    assign is_valid_cmd = is_prog_cmd
        || cmd_data_in == flash_prog_pkg::CMD_READ_ARRAY
        || cmd_data_in == flash_prog_pkg::CMD_READ_STATUS
        || cmd_data_in == flash_prog_pkg::CMD_CLEAR_STATUS
        || cmd_data_in == flash_prog_pkg::CMD_PRODUCT_ID
        || cmd_data_in == flash_prog_pkg::CMD_ERASE_SECTOR
        || cmd_data_in == flash_prog_pkg::CMD_ERASE_UNIF
        || cmd_data_in == flash_prog_pkg::CMD_ERASE_CONF;

    assign busy = (eng_q == ENG_PROG) | erase_busy_in;

    // second write of a program carries address and data
    assign prog_accept = cmd_wr_in && mode_q == MODE_PROG2;
    assign prog_start  = prog_accept && !target_locked;
    assign prog_reject = prog_accept && target_locked;

    assign clear_status = cmd_wr_in && mode_q != MODE_PROG2
                       && cmd_data_in == flash_prog_pkg::CMD_CLEAR_STATUS;

    // while busy only status commands and a silent read-array pass;
    // anything else is a sequence error rather than being queued
    assign seq_error = cmd_wr_in && busy && mode_q != MODE_PROG2
        && cmd_data_in != flash_prog_pkg::CMD_READ_STATUS
        && cmd_data_in != flash_prog_pkg::CMD_CLEAR_STATUS
        && cmd_data_in != flash_prog_pkg::CMD_READ_ARRAY;

    // ============================================================
    // command user interface mode
    always_comb begin
        mode_d = mode_q;
        if (prog_accept) begin
            mode_d = MODE_STATUS;
        end else if (cmd_wr_in && is_valid_cmd) begin
            // any valid code but product id leaves id mode; read-array only when not busy
            unique case (cmd_data_in)
                flash_prog_pkg::CMD_READ_ARRAY: begin
                    if (!busy) begin
                        mode_d = MODE_ARRAY;
                    end
                end
                flash_prog_pkg::CMD_PRODUCT_ID: begin
                    if (!busy) begin
                        mode_d = MODE_ID;
                    end
                end
                flash_prog_pkg::CMD_PROGRAM_A,
                flash_prog_pkg::CMD_PROGRAM_B: begin
                    mode_d = busy ? MODE_STATUS : MODE_PROG2;
                end
                flash_prog_pkg::CMD_CLEAR_STATUS: begin
                    mode_d = (mode_q == MODE_ID) ? MODE_ARRAY : mode_q;
                end
                default: begin
                    // read status, and erase codes handled elsewhere
                    mode_d = MODE_STATUS;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_q <= MODE_ARRAY;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ============================================================
    // internal write state machine for byte program
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            eng_q <= ENG_IDLE;
        end else begin
            unique case (eng_q)
                ENG_IDLE: begin
                    if (prog_start && !erase_busy_in) begin
                        eng_q <= ENG_PROG;
                    end
                end
                ENG_PROG: begin
                    if (timer_done) begin
                        eng_q <= ENG_IDLE;
                    end
                end
            endcase
        end
    end

    // latch target and data once; they hold through the pulse
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prog_addr_out <= '0;
            prog_data_out <= 8'hff;
        end else if (prog_start && eng_q == ENG_IDLE) begin
            prog_addr_out <= cmd_addr_in;
            // zero bits are cleared, ones leave the cell alone
            prog_data_out <= cmd_data_in;
        end
    end

    program_pulse_timer u_timer (
        .clk_sys_in (clk_sys_in),
        .resetn_in  (resetn_in),
        .start_in   (prog_start && eng_q == ENG_IDLE && !erase_busy_in),
        .pulse_out  (timer_pulse),
        .done_out   (timer_done)
    );

    assign prog_pulse_out = timer_pulse;

    // ============================================================
    // error flags: set wins over a clear in the same cycle
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            erase_err_q <=
                flash_prog_pkg::ST_RESET[flash_prog_pkg::ST_ERASE_BIT];
        end else if (seq_error || (erase_done_in && erase_fail_in)) begin
            erase_err_q <= 1'b1;
        end else if (clear_status) begin
            erase_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            prog_err_q <=
                flash_prog_pkg::ST_RESET[flash_prog_pkg::ST_PROG_BIT];
        end else if (seq_error || prog_reject) begin
            prog_err_q <= 1'b1;
        end else if (clear_status) begin
            prog_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            protect_err_q <=
                flash_prog_pkg::ST_RESET[flash_prog_pkg::ST_PROTECT_BIT];
        end else if (prog_reject || (erase_done_in && erase_locked_in)) begin
            protect_err_q <= 1'b1;
        end else if (clear_status) begin
            protect_err_q <= 1'b0;
        end
    end

    // ============================================================
    // status byte assembly; reserved bits are held at zero
    always_comb begin
        status = 8'h00;
        status[flash_prog_pkg::ST_READY_BIT]   = !busy;
        status[flash_prog_pkg::ST_ERASE_BIT]   = erase_err_q;
        status[flash_prog_pkg::ST_PROG_BIT]    = prog_err_q;
        status[flash_prog_pkg::ST_PROTECT_BIT] = protect_err_q;
    end

    assign status_out = status;

    // ============================================================
    // identification bytes; other addresses read zero
    always_comb begin
        id_byte = 8'h00;
        if (rd_addr_in == flash_prog_pkg::ID_MFR_ADDR) begin
            id_byte = flash_prog_pkg::ID_MFR_CODE;
        end else if (rd_addr_in == flash_prog_pkg::ID_DEV_ADDR) begin
            id_byte = flash_prog_pkg::ID_DEV_CODE;
        end
    end

    // ============================================================
    // read data register, one cycle after the read strobe
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_out <= '0;
        end else if (rd_in) begin
            unique case (mode_q)
                MODE_ARRAY:  rd_data_out <= array_rd_data_in;
                MODE_ID:     rd_data_out <= id_byte;
                // status also answers while a second cycle is awaited
                MODE_STATUS,
                MODE_PROG2:  rd_data_out <= status;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_valid_out <= 1'b0;
        end else begin
            rd_valid_out <= rd_in;
        end
    end

    // ============================================================
    // busy indication; open-drain pin pulled low while busy
    assign busy_out            = busy;
    assign ready_busy_out      = 1'b0;
    assign ready_busy_oe_n_out = !busy;

endmodule

// [flash_prog_pkg.sv]
// ============================================================
// shared constants for the program / status / identification logic
package flash_prog_pkg;

    // ============================================================
    // widths
    localparam int ADDR_W = 19;   // byte address a18..a0
    localparam int DATA_W = 8;

    // ============================================================
    // first-cycle command codes
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
    localparam logic [7:0] CMD_PROGRAM_A    = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_B    = 8'h10;
    localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PRODUCT_ID   = 8'h90;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h21;
    localparam logic [7:0] CMD_ERASE_UNIF   = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONF   = 8'hd0;

    // ============================================================
    // operation_status_flags field positions
    localparam int ST_READY_BIT   = 7;
    localparam int ST_ERASE_BIT   = 5;
    localparam int ST_PROG_BIT    = 4;
    localparam int ST_PROTECT_BIT = 1;
    localparam logic [7:0] ST_RESET = 8'h00;  // error flags clear

    // ============================================================
    // identification addresses and codes
    localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 19'h00001;
    localparam logic [7:0] ID_MFR_CODE = 8'h5a;  // arbitrary value
    localparam logic [7:0] ID_DEV_CODE = 8'ha5;  // arbitrary value

    // ============================================================
    // top boot sector: uppermost 32 kbyte, a18..a15 all ones
    localparam int         TOP_SEC_LSB = 15;
    localparam logic [3:0] TOP_SEC_TAG = 4'hf;

    // ============================================================
    // self-timed program duration
    localparam int CLK_MHZ       = 125;
    localparam int PROG_TIME_US  = 20;
    localparam int PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
    localparam int PROG_CNT_W    = 12;
    localparam int SYNC_STAGES   = 2;

endpackage

// [program_pulse_timer.sv]
`timescale 1ns/100ps
// ============================================================
// self-timed program pulse: busy for a fixed count, then one done pulse
module program_pulse_timer (
    // clock and reset
    input  wire logic clk_sys_in,
    input  wire logic resetn_in,
    // control
    input  wire logic start_in,
    // status
    output logic      pulse_out,
    output logic      done_out
);

    localparam logic [flash_prog_pkg::PROG_CNT_W-1:0] LAST =
        flash_prog_pkg::PROG_CNT_W'(flash_prog_pkg::PROG_CYCLES - 1);

    logic [flash_prog_pkg::PROG_CNT_W-1:0] cnt_q;

    // ============================================================
    // count down the pulse; a start while running is ignored
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pulse_out <= 1'b0;
            cnt_q     <= '0;
        end else if (start_in && !pulse_out) begin
            pulse_out <= 1'b1;
            cnt_q     <= LAST;
        end else if (pulse_out && cnt_q == '0) begin
            pulse_out <= 1'b0;
        end else if (pulse_out) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // one-cycle completion pulse as the pulse ends
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_out <= 1'b0;
        end else begin
            done_out <= pulse_out && cnt_q == '0;
        end
    end

endmodule

// [prog_status_checker_assertions.sv]
`timescale 1ns/100ps
// ============================================================
// port-level checks of the block
module prog_status_checker (
    // clock and reset
    input wire logic        clk_sys_in,
    input wire logic        resetn_in,
    // watched ports
    input wire logic        cmd_wr_in,
    input wire logic [7:0]  cmd_data_in,
    input wire logic        rd_in,
    input wire logic        rd_valid_out,
    input wire logic        prog_pulse_out,
    input wire logic [18:0] prog_addr_out,
    input wire logic [7:0]  prog_data_out,
    input wire logic        erase_busy_in,
    input wire logic        busy_out,
    input wire logic        ready_busy_out,
    input wire logic        ready_busy_oe_n_out,
    input wire logic [7:0]  status_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);

    // ============================================================
    // cycles of the current program pulse
    logic [15:0] pulse_cnt_q;
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in)
            pulse_cnt_q <= 16'h0000;
        else
            pulse_cnt_q <= prog_pulse_out ? pulse_cnt_q + 16'h0001 : 16'h0000;
    end

    // ============================================================
    // assertions
    a_reserved_zero:
        assert property ((status_out & 8'h4d) == 8'h00)
        else $error("reserved status bits not zero");
    a_ready_bit:
        assert property (status_out[7] == !busy_out)
        else $error("ready bit disagrees with busy");
    a_pin_follows_busy:
        assert property (ready_busy_oe_n_out == !busy_out && !ready_busy_out)
        else $error("ready pin enable disagrees with busy");
    a_read_answer:
        assert property (rd_in |=> rd_valid_out)
        else $error("read answer missing");
    a_pulse_length:
        assert property ($fell(prog_pulse_out) |->
            pulse_cnt_q == 16'(flash_prog_pkg::PROG_CYCLES))
        else $error("program pulse length wrong");
    a_pulse_busy:
        assert property (prog_pulse_out |-> busy_out && !status_out[7])
        else $error("pulse without busy");
    a_target_stable:
        assert property (prog_pulse_out && $past(prog_pulse_out) |->
            $stable(prog_addr_out) && $stable(prog_data_out))
        else $error("program target moved during pulse");
    a_pulse_cause:
        assert property ($rose(prog_pulse_out) |->
            $past(cmd_wr_in) || $past(cmd_wr_in, 2))
        else $error("pulse without a write cycle");
    a_flag_clear_cause:
        assert property (status_out[7] && $past(status_out[7]) &&
            (($past(status_out) & ~status_out & 8'h32) != 8'h00) |->
            $past(cmd_wr_in) &&
            $past(cmd_data_in) == flash_prog_pkg::CMD_CLEAR_STATUS)
        else $error("error flag cleared without clear command");
    a_done_ready:
        assert property ($fell(prog_pulse_out) |->
            ##[0:3] (!busy_out || erase_busy_in))
        else $error("not ready after program pulse");
endmodule

bind flash_program_status_id_logic prog_status_checker u_chk (
    .clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .cmd_wr_in(cmd_wr_in), .cmd_data_in(cmd_data_in), .rd_in(rd_in),
    .rd_valid_out(rd_valid_out), .prog_pulse_out(prog_pulse_out),
    .prog_addr_out(prog_addr_out), .prog_data_out(prog_data_out),
    .erase_busy_in(erase_busy_in), .busy_out(busy_out),
    .ready_busy_out(ready_busy_out),
    .ready_busy_oe_n_out(ready_busy_oe_n_out), .status_out(status_out)
);

// [host_cycle_model.sv]
`timescale 1ns/100ps
// ============================================================
// host side: command write and read cycles plus a fake array
module host_cycle_model (
    // clock
    input  wire logic        clk_sys_in,
    // read answer
    input  wire logic        rd_valid_in,
    input  wire logic [7:0]  rd_data_in,
    // cycles towards the device
    output logic             cmd_wr_out,
    output logic [18:0]      cmd_addr_out,
    output logic [7:0]       cmd_data_out,
    output logic             rd_out,
    output logic [18:0]      rd_addr_out,
    output logic [7:0]       array_data_out
);
    // array byte derived from the address so every read is predictable
    assign array_data_out = rd_addr_out[7:0] ^ 8'h3c;

    initial begin
        {cmd_wr_out, cmd_addr_out, cmd_data_out, rd_out, rd_addr_out} = '0;
    end

    // one write cycle; a byte program takes two
    task automatic wr(input logic [18:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        cmd_wr_out   <= 1'b1;
        cmd_addr_out <= a;
        cmd_data_out <= d;
        @(posedge clk_sys_in);
        cmd_wr_out   <= 1'b0;
        cmd_addr_out <= ~a; // released lines show no stale value
        cmd_data_out <= ~d;
        #1;
    endtask

    // one read cycle, answer taken one cycle after the strobe
    task automatic rd(input logic [18:0] a, output logic [7:0] d,
                      output logic v);
        @(posedge clk_sys_in);
        rd_out      <= 1'b1;
        rd_addr_out <= a;
        @(posedge clk_sys_in);
        {rd_out, rd_addr_out} <= {1'b0, ~a};
        #1;
        d = rd_data_in;
        v = rd_valid_in;
    endtask
endmodule

// [flash_program_status_id_logic_test.sv]
`timescale 1ns/100ps
// ============================================================
// self-checking bench
module flash_program_status_id_logic_test;
    logic        clk_sys_in, resetn_in, lock, top_n, wp_n;
    logic        e_busy, e_done, e_fail, e_lock, cmd_wr, rd, rd_valid;
    logic        pulse, busy, rb, rb_oe_n, rval;
    logic [18:0] cmd_addr, rd_addr, prog_addr, pa;
    logic [7:0]  cmd_data, arr, rd_data, prog_data, status, rdat, pd;
    int          mismatches = 0, comparisons = 0;

    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    host_cycle_model host (.clk_sys_in, .rd_valid_in(rd_valid),
        .rd_data_in(rd_data), .cmd_wr_out(cmd_wr), .cmd_addr_out(cmd_addr),
        .cmd_data_out(cmd_data), .rd_out(rd), .rd_addr_out(rd_addr),
        .array_data_out(arr));

    flash_program_status_id_logic dut (.clk_sys_in,
        .resetn_in, .cmd_wr_in(cmd_wr), .cmd_addr_in(cmd_addr),
        .cmd_data_in(cmd_data), .rd_in(rd), .rd_addr_in(rd_addr),
        .rd_valid_out(rd_valid), .rd_data_out(rd_data),
        .array_rd_data_in(arr), .prog_pulse_out(pulse),
        .prog_addr_out(prog_addr), .prog_data_out(prog_data),
        .sector_lock_in(lock), .top_boot_lock_pin_n_in(top_n),
        .write_protect_n_in(wp_n), .erase_busy_in(e_busy),
        .erase_done_in(e_done), .erase_fail_in(e_fail),
        .erase_locked_in(e_lock), .busy_out(busy), .ready_busy_out(rb),
        .ready_busy_oe_n_out(rb_oe_n), .status_out(status));

    // ============================================================
    // verdict and compares
    task automatic conclude;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chkv(input logic [18:0] got, input logic [18:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chkv(19'(got), 19'(exp));
    endtask

    // ============================================================
    // host cycle sequences
    task automatic rdchk(input logic [18:0] a, input logic [7:0] e);
        host.rd(a, rdat, rval);
        chkb(rval, 1'b1);
        chkv(19'(rdat), 19'(e));
    endtask
    task automatic prog(input logic [7:0] c, input logic [18:0] a,
                        input logic [7:0] d, input logic lk);
        @(posedge clk_sys_in) lock <= lk;
        host.wr(a, c);
        host.wr(a, d);
    endtask
    // bounded wait, the pulse is 2500 cycles
    task automatic wait_idle;
        for (int n = 0; n < 3000 && busy !== 1'b0; n++)
            @(posedge clk_sys_in);
        #1;
        chkb(busy, 1'b0);
    endtask
    task automatic erase_ev(input logic f, input logic lk);
        @(posedge clk_sys_in) e_busy <= 1'b1;
        @(posedge clk_sys_in);
        {e_done, e_fail, e_lock} <= {1'b1, f, lk};
        @(posedge clk_sys_in);
        {e_done, e_busy} <= 2'b00;
        #1;
    endtask

    // watchdog: three program pulses plus margin
    initial begin
        #240000;
        mismatches++;
        conclude();
    end

    // ============================================================
    // main sequence
    initial begin
        {resetn_in, lock, e_busy, e_done, e_fail, e_lock} = 6'h00;
        {top_n, wp_n} = 2'b11;
        repeat (5) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        #1;
        chkv(status, 8'h80);
        chkb(rb_oe_n, 1'b1);
        chkv(prog_data, 8'hff);
        rdchk(19'h00005, 8'h39);
        host.wr(19'h01234, flash_prog_pkg::CMD_PRODUCT_ID);
        rdchk(19'h00000, flash_prog_pkg::ID_MFR_CODE);
        rdchk(19'h00001, flash_prog_pkg::ID_DEV_CODE);
        host.wr(19'h7abcd, flash_prog_pkg::CMD_READ_STATUS);
        rdchk(19'h00003, 8'h80);
        // both program codes, with status poll and array read while busy
        for (int i = 0; i < 2; i++) begin
            pa = 19'h01230 + 19'(i);
            pd = 8'h5a ^ 8'(i);
            prog(i ? flash_prog_pkg::CMD_PROGRAM_B
                   : flash_prog_pkg::CMD_PROGRAM_A, pa, pd, 1'b0);
            chkb(pulse, 1'b1);
            chkv(prog_addr, pa);
            chkv(19'(prog_data), 19'(pd));
            chkb(status[7], 1'b0);
            host.wr(19'h7f00f, flash_prog_pkg::CMD_READ_STATUS);
            host.wr(19'h00000, flash_prog_pkg::CMD_READ_ARRAY);
            host.rd(19'h00005, rdat, rval);
            chkb(rdat[7], 1'b0);
            wait_idle();
            chkv(status, 8'h80);
            rdchk(19'h00005, 8'h80);
        end
        // locked sector, flags survive other commands
        prog(flash_prog_pkg::CMD_PROGRAM_A, 19'h02000, 8'h0f, 1'b1);
        chkb(pulse, 1'b0);
        chkv(status, 8'h92);
        host.wr(19'h00000, flash_prog_pkg::CMD_PRODUCT_ID);
        chkv(status, 8'h92);
        host.wr(19'h12345, flash_prog_pkg::CMD_CLEAR_STATUS);
        chkv(status, 8'h80);
        rdchk(19'h00001, 8'h3d);
        // protect pins, sampled only at the attempt
        @(posedge clk_sys_in) wp_n <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        prog(flash_prog_pkg::CMD_PROGRAM_B, 19'h04000, 8'h00, 1'b0);
        chkv(status, 8'h92);
        @(posedge clk_sys_in) wp_n <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1;
        chkv(status, 8'h92);
        host.wr(19'h00000, flash_prog_pkg::CMD_CLEAR_STATUS);
        @(posedge clk_sys_in) top_n <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        prog(flash_prog_pkg::CMD_PROGRAM_A, 19'h7ffff, 8'h00, 1'b0);
        chkv(status, 8'h92);
        host.wr(19'h00000, flash_prog_pkg::CMD_CLEAR_STATUS);
        prog(flash_prog_pkg::CMD_PROGRAM_A, 19'h04001, 8'h3c, 1'b0);
        chkb(pulse, 1'b1);
        wait_idle();
        @(posedge clk_sys_in) top_n <= 1'b1;
        // erase outcomes and a sequence error while the erase runs
        erase_ev(1'b1, 1'b0);
        chkv(status, 8'ha0);
        erase_ev(1'b1, 1'b1);
        chkv(status, 8'ha2);
        host.wr(19'h00000, flash_prog_pkg::CMD_CLEAR_STATUS);
        erase_ev(1'b0, 1'b0);
        chkv(status, 8'h80);
        @(posedge clk_sys_in) e_busy <= 1'b1;
        #1;
        chkb(busy, 1'b1);
        chkb(rb_oe_n, 1'b0);
        host.wr(19'h00000, flash_prog_pkg::CMD_PROGRAM_A);
        @(posedge clk_sys_in) e_busy <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        chkv(status, 8'hb0);
        host.wr(19'h00000, flash_prog_pkg::CMD_CLEAR_STATUS);
        chkv(status, 8'h80);
        conclude();
    end
endmodule
